// >>> oos_host_model.sv
// host controller model: register writes, register reads and command pulses
// assumes the bench calls its tasks after reset; drives just after rising edges
`timescale 1ns/1ns

module oos_host_model
(
   input  wire logic       ref_clk_i,    // device clock
   output logic      [7:0] reg_addr_o,   // register address
   output logic            reg_wr_o,     // write strobe
   output logic            reg_rd_o,     // read strobe
   output logic      [7:0] reg_wdata_o,  // write data
   input  wire logic [7:0] reg_rdata_i,  // read data
   output logic            on_cmd_o,     // turn-on pulse
   output logic            off_cmd_o     // turn-off pulse
);

   // ----------------------------------------------------------------
   // idle levels
   // ----------------------------------------------------------------
   initial
   begin
      reg_addr_o  = 8'h00;
      reg_wr_o    = 1'b0;
      reg_rd_o    = 1'b0;
      reg_wdata_o = 8'h00;
      on_cmd_o    = 1'b0;
      off_cmd_o   = 1'b0;
   end

   // ----------------------------------------------------------------
   // register port cycles
   // ----------------------------------------------------------------
   // one write; data inverted afterwards so stale values never look valid
   task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
      @(posedge ref_clk_i);
      reg_addr_o  <= addr;
      reg_wdata_o <= data;
      reg_wr_o    <= 1'b1;
      @(posedge ref_clk_i);
      reg_wr_o    <= 1'b0;
      reg_wdata_o <= ~data;
      reg_addr_o  <= ~addr;
   endtask : write_reg

   // one read; data taken the cycle after the strobe edge
   task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
      @(posedge ref_clk_i);
      reg_addr_o <= addr;
      reg_rd_o   <= 1'b1;
      @(posedge ref_clk_i);
      reg_rd_o   <= 1'b0;
      reg_addr_o <= ~addr;
      @(posedge ref_clk_i);
      data = reg_rdata_i;
   endtask : read_reg

   // one-cycle command pulse, on when high, off when low
   task automatic command(input logic turn_on);
      @(posedge ref_clk_i);
      on_cmd_o  <= turn_on;
      off_cmd_o <= ~turn_on;
      @(posedge ref_clk_i);
      on_cmd_o  <= 1'b0;
      off_cmd_o <= 1'b0;
   endtask : command

endmodule : oos_host_model

// >>> oos_pkg.sv
// types shared by the output turn-on/turn-off sequencer
// assumes the map header sits in the same folder
package oos_pkg;

   // ----------------------------------------------------------------
   // sequencer states
   // ----------------------------------------------------------------
   typedef enum logic [2:0]
   {
      OOS_OFF,
      OOS_ON_WAIT,
      OOS_RAMP_UP,
      OOS_ON,
      OOS_OFF_HOLD,
      OOS_RAMP_DOWN
   } oos_state_e;

   typedef logic [8:0] oos_steps_t;   // voltage in 12.5 mV steps

endpackage : oos_pkg

// >>> oos_seq_map.svh
// register map, field layout, reset values and timing figures of the output sequencer
// assumes inclusion by bare name from the sequencer module
`ifndef OOS_SEQ_MAP_SVH
`define OOS_SEQ_MAP_SVH

// ----------------------------------------------------------------
// register addresses
// ----------------------------------------------------------------
`define OOS_ADDR_TRACK_CFG     8'h03
`define OOS_ADDR_ON_DELAY      8'h05
`define OOS_ADDR_OFF_DELAY     8'h06
`define OOS_ADDR_CUR_LIMIT     8'h08

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define OOS_RST_TRACK_CFG      8'h08
`define OOS_RST_ON_DELAY       8'h00
`define OOS_RST_OFF_DELAY      8'h00
`define OOS_RST_CUR_LIMIT      8'h00

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define OOS_TC_RISE_HI         6
`define OOS_TC_RISE_LO         4
`define OOS_TC_SLEW_EN         3
`define OOS_TC_FALL_HI         2
`define OOS_TC_FALL_LO         0
`define OOS_TC_IMPL_MASK       8'h7F
`define OOS_OFF_IMPL_MASK      8'h3F
`define OOS_CLS_DROOP_HI       3
`define OOS_CLS_DROOP_LO       0
`define OOS_DROOP_SHIFT        4

// ----------------------------------------------------------------
// timing: clock period and millisecond tick, in ns
// ----------------------------------------------------------------
`define OOS_CLK_PERIOD_NS      10
`define OOS_MS_TICK_NS         1000000

// time of one 12.5 mV step, in ns, for each slew code 0..7
`define OOS_STEP0_NS           125000
`define OOS_STEP1_NS           62500
`define OOS_STEP2_NS           25000
`define OOS_STEP3_NS           12500
`define OOS_STEP4_NS           6250
`define OOS_STEP5_NS           2500
`define OOS_STEP6_NS           1506
`define OOS_STEP7_NS           1506

`endif

// >>> oos_sequencer.sv
// output turn-on/turn-off sequencer of a digital point-of-load converter
// assumes register accesses and commands arrive on ref_clk_i from the serial-bus decoder
`timescale 1ns/1ns
`include "oos_seq_map.svh"

// Operation
// - turn-on waits programmed delay before ramping
// - turn-on delay 8 bits, one ms units
// - turn-off delay 6 bits, one ms units
// - turn-off delay bits 7:6 read zero
// - slewed turn-off delay ends at zero volts
// - unslewed turn-off delay ends opening both switches
// - hold time is delay minus ramp-down time
// - unslewed decay left to the load
// - load regulation lowers voltage as current rises
// - ramps move in 12.5 mV steps
module oos_sequencer
   import oos_pkg::*;
#(
   parameter int MS_TICK_CYCLES = `OOS_MS_TICK_NS / `OOS_CLK_PERIOD_NS,   // one ms
   parameter int STEP0_CYCLES   = `OOS_STEP0_NS / `OOS_CLK_PERIOD_NS,     // 0.1 V/ms step
   parameter int STEP1_CYCLES   = `OOS_STEP1_NS / `OOS_CLK_PERIOD_NS      // 0.2 V/ms step
)
(
   input  wire logic       ref_clk_i,        // device clock
   input  wire logic       rst_i,            // synchronous reset, high
   input  wire logic [7:0] reg_addr_i,       // register address
   input  wire logic       reg_wr_i,         // write strobe
   input  wire logic       reg_rd_i,         // read strobe
   input  wire logic [7:0] reg_wdata_i,      // write data
   output logic      [7:0] reg_rdata_o,      // read data, one cycle after strobe
   input  wire logic       turn_on_cmd_i,    // turn-on command pulse
   input  wire logic       turn_off_cmd_i,   // turn-off command pulse
   input  wire logic [8:0] target_steps_i,   // setpoint in 12.5 mV steps
   input  wire logic [7:0] iout_i,           // output current monitor
   output logic      [8:0] vout_ref_o,       // regulated reference, 12.5 mV steps
   output logic            stage_en_o        // high: switches driven, low: both open
);

   // ----------------------------------------------------------------
   // constants derived from the map
   // ----------------------------------------------------------------
   localparam logic [16:0] MS_LAST = 17'(MS_TICK_CYCLES - 1);   // last tick count
   localparam logic [25:0] MS_W    = 26'(MS_TICK_CYCLES);       // tick length, wide

   // step length lookup for a slew code
   function automatic logic [15:0] step_cycles(input logic [2:0] code);
      logic [15:0] c;
      c = 16'(`OOS_STEP7_NS / `OOS_CLK_PERIOD_NS);
      case (code)
         3'd0:    c = 16'(STEP0_CYCLES);
         3'd1:    c = 16'(STEP1_CYCLES);
         3'd2:    c = 16'(`OOS_STEP2_NS / `OOS_CLK_PERIOD_NS);
         3'd3:    c = 16'(`OOS_STEP3_NS / `OOS_CLK_PERIOD_NS);
         3'd4:    c = 16'(`OOS_STEP4_NS / `OOS_CLK_PERIOD_NS);
         3'd5:    c = 16'(`OOS_STEP5_NS / `OOS_CLK_PERIOD_NS);
         3'd6:    c = 16'(`OOS_STEP6_NS / `OOS_CLK_PERIOD_NS);
         default: c = 16'(`OOS_STEP7_NS / `OOS_CLK_PERIOD_NS);
      endcase
      return c;
   endfunction : step_cycles

   // ----------------------------------------------------------------
   // register file
   // ----------------------------------------------------------------
   logic [7:0] track_cfg_reg,         track_cfg_next;          // slew config
   logic [7:0] turn_on_delay_reg,     turn_on_delay_next;      // ms
   logic [7:0] turn_off_delay_reg,    turn_off_delay_next;     // ms, bits 5:0
   logic [7:0] current_limit_setpoint_reg, current_limit_setpoint_next;
   logic [7:0] rdata_reg,             rdata_next;              // read data

   // write decode and read mux
   always_comb
   begin
      track_cfg_next              = track_cfg_reg;
      turn_on_delay_next          = turn_on_delay_reg;
      turn_off_delay_next         = turn_off_delay_reg;
      current_limit_setpoint_next = current_limit_setpoint_reg;
      rdata_next                  = rdata_reg;
      if (reg_wr_i)   // host programs sequencing
      begin
         case (reg_addr_i)
            `OOS_ADDR_TRACK_CFG: track_cfg_next      = reg_wdata_i & `OOS_TC_IMPL_MASK;
            `OOS_ADDR_ON_DELAY:  turn_on_delay_next  = reg_wdata_i;
            `OOS_ADDR_OFF_DELAY: turn_off_delay_next = reg_wdata_i & `OOS_OFF_IMPL_MASK;
            `OOS_ADDR_CUR_LIMIT: current_limit_setpoint_next = reg_wdata_i;
            default:             ;   // unmapped write ignored
         endcase
      end
      if (reg_rd_i)
      begin
         case (reg_addr_i)
            `OOS_ADDR_TRACK_CFG: rdata_next = track_cfg_reg;
            `OOS_ADDR_ON_DELAY:  rdata_next = turn_on_delay_reg;
            `OOS_ADDR_OFF_DELAY: rdata_next = turn_off_delay_reg & `OOS_OFF_IMPL_MASK;
            `OOS_ADDR_CUR_LIMIT: rdata_next = current_limit_setpoint_reg;
            default:             rdata_next = 8'h00;   // unmapped reads zero
         endcase
      end
   end

   // register storage
   always_ff @(posedge ref_clk_i)
   begin
      if (rst_i)
      begin
         track_cfg_reg              <= `OOS_RST_TRACK_CFG;
         turn_on_delay_reg          <= `OOS_RST_ON_DELAY;
         turn_off_delay_reg         <= `OOS_RST_OFF_DELAY;
         current_limit_setpoint_reg <= `OOS_RST_CUR_LIMIT;
         rdata_reg                  <= 8'h00;
      end
      else
      begin
         track_cfg_reg              <= track_cfg_next;
         turn_on_delay_reg          <= turn_on_delay_next;
         turn_off_delay_reg         <= turn_off_delay_next;
         current_limit_setpoint_reg <= current_limit_setpoint_next;
         rdata_reg                  <= rdata_next;
      end
   end

   // ----------------------------------------------------------------
   // sequencer
   // ----------------------------------------------------------------
   oos_state_e  state_reg,   state_next;     // sequence state
   logic [16:0] tick_reg,    tick_next;      // cycles within current ms
   logic [7:0]  ms_left_reg, ms_left_next;   // whole ms remaining
   logic [15:0] step_reg,    step_next;      // cycles within current step
   oos_steps_t  vout_reg,    vout_next;      // unloaded reference
   logic        stage_reg,   stage_next;     // power stage enable

   logic        slew_en;                     // slew control enabled
   logic [15:0] rise_len;                    // rising step length
   logic [15:0] fall_len;                    // falling step length
   logic        ms_tick;                     // last cycle of a ms
   logic [25:0] remain_cyc;                  // cycles left in off delay
   logic [25:0] ramp_cyc;                    // cycles the ramp-down needs

   assign slew_en  = track_cfg_reg[`OOS_TC_SLEW_EN];
   assign rise_len = step_cycles(track_cfg_reg[`OOS_TC_RISE_HI:`OOS_TC_RISE_LO]);
   assign fall_len = step_cycles(track_cfg_reg[`OOS_TC_FALL_HI:`OOS_TC_FALL_LO]);
   assign ms_tick  = (tick_reg == MS_LAST);
   // time left in the delay, and ramp time = vout / falling slew
   // whole ms left count from the start of this ms, so the cycles already spent in this ms come off
   assign remain_cyc = 26'(ms_left_reg) * MS_W - 26'(tick_reg);
   assign ramp_cyc   = 26'(vout_reg) * 26'(fall_len);

   // next state and counters
   always_comb
   begin
      state_next   = state_reg;
      tick_next    = ms_tick ? 17'h0_0000 : tick_reg + 17'h0_0001;
      ms_left_next = (ms_tick && ms_left_reg != 8'h00) ? ms_left_reg - 8'h01 : ms_left_reg;
      step_next    = step_reg;
      vout_next    = vout_reg;
      stage_next   = stage_reg;
      if (turn_on_cmd_i)   // turn-on restarts the delay
      begin
         state_next   = OOS_ON_WAIT;
         tick_next    = 17'h0_0000;
         ms_left_next = turn_on_delay_reg;
      end
      else if (turn_off_cmd_i && state_reg != OOS_OFF)   // turn-off restarts
      begin
         state_next   = OOS_OFF_HOLD;
         tick_next    = 17'h0_0000;
         ms_left_next = turn_off_delay_reg & `OOS_OFF_IMPL_MASK;
      end
      else
      begin
         case (state_reg)
            OOS_OFF:
            begin
               vout_next  = 9'h000;
               stage_next = 1'b0;
            end
            OOS_ON_WAIT:   // output held until delay runs out
            begin
               if (ms_left_reg == 8'h00)
               begin
                  state_next = OOS_RAMP_UP;
                  stage_next = 1'b1;
                  step_next  = 16'h0000;
               end
            end
            OOS_RAMP_UP:
            begin
               if (!slew_en || vout_reg >= target_steps_i)
               begin
                  vout_next  = target_steps_i;
                  state_next = OOS_ON;
               end
               else if (step_reg >= rise_len - 16'h0001)
               begin
                  vout_next = vout_reg + 9'h001;   // one 12.5 mV step
                  step_next = 16'h0000;
               end
               else
                  step_next = step_reg + 16'h0001;
            end
            OOS_ON:
               vout_next = target_steps_i;   // follow setpoint
            OOS_OFF_HOLD:
            begin
               if (slew_en)
               begin
                  // hold ends when ramp just fits, or at once if host left no margin
                  if (remain_cyc <= ramp_cyc || ms_left_reg == 8'h00)
                  begin
                     state_next = OOS_RAMP_DOWN;
                     step_next  = 16'h0000;
                  end
               end
               else if (ms_left_reg == 8'h00)
               begin
                  // open both switches, decay left to the load
                  state_next = OOS_OFF;
                  stage_next = 1'b0;
                  vout_next  = 9'h000;   // no shaping
               end
            end
            OOS_RAMP_DOWN:
            begin
               if (vout_reg == 9'h000)   // delay ends at zero volts
               begin
                  state_next = OOS_OFF;
                  stage_next = 1'b0;
               end
               else if (step_reg >= fall_len - 16'h0001)
               begin
                  vout_next = vout_reg - 9'h001;   // one 12.5 mV step
                  step_next = 16'h0000;
               end
               else
                  step_next = step_reg + 16'h0001;
            end
            default:
            begin
               state_next = OOS_OFF;
               stage_next = 1'b0;
               vout_next  = 9'h000;
            end
         endcase
      end
   end

   // sequencer storage
   always_ff @(posedge ref_clk_i)
   begin
      if (rst_i)
      begin
         state_reg   <= OOS_OFF;
         tick_reg    <= 17'h0_0000;
         ms_left_reg <= 8'h00;
         step_reg    <= 16'h0000;
         vout_reg    <= 9'h000;
         stage_reg   <= 1'b0;
      end
      else
      begin
         state_reg   <= state_next;
         tick_reg    <= tick_next;
         ms_left_reg <= ms_left_next;
         step_reg    <= step_next;
         vout_reg    <= vout_next;
         stage_reg   <= stage_next;
      end
   end

   // ----------------------------------------------------------------
   // load-line positioning
   // ----------------------------------------------------------------
   logic [8:0]  ref_reg, ref_next;   // registered regulated reference
   logic [11:0] droop;               // drop in steps
   logic [3:0]  droop_gain;          // gain from current-limit setpoint

   assign droop_gain = current_limit_setpoint_reg[`OOS_CLS_DROOP_HI:`OOS_CLS_DROOP_LO];
   assign droop      = 12'((12'(iout_i) * 12'(droop_gain)) >> `OOS_DROOP_SHIFT);

   // reference falls as current rises, floor at zero
   always_comb
   begin
      ref_next = (12'(vout_reg) > droop) ? 9'(12'(vout_reg) - droop) : 9'h000;
   end

   // reference storage
   always_ff @(posedge ref_clk_i)
   begin
      if (rst_i)
         ref_reg <= 9'h000;
      else
         ref_reg <= ref_next;
   end

   assign reg_rdata_o = rdata_reg;
   assign vout_ref_o  = ref_reg;
   assign stage_en_o  = stage_reg;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   a_on_restart: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      turn_on_cmd_i |=> state_reg == OOS_ON_WAIT && tick_reg == 17'h0_0000
                        && ms_left_reg == $past(turn_on_delay_reg))
      else $error("turn-on did not restart delay");

   a_wait_no_ramp: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      state_reg == OOS_ON_WAIT && ms_left_reg != 8'h00 && !turn_on_cmd_i && !turn_off_cmd_i
         |=> state_reg == OOS_ON_WAIT)
      else $error("ramp began before delay ended");

   a_off_read_zero: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      reg_rd_i && reg_addr_i == `OOS_ADDR_OFF_DELAY |=> reg_rdata_o[7:6] == 2'b00)
      else $error("unimplemented off delay bits read nonzero");

   a_off_delay_load: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      turn_off_cmd_i && !turn_on_cmd_i && state_reg != OOS_OFF
         |=> ms_left_reg == ($past(turn_off_delay_reg) & `OOS_OFF_IMPL_MASK))
      else $error("off delay loaded wrongly");

   a_nosc_open: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      state_reg == OOS_OFF_HOLD && !slew_en && ms_left_reg == 8'h00
      && !turn_on_cmd_i && !turn_off_cmd_i |=> !stage_en_o && state_reg == OOS_OFF)
      else $error("switches not opened at end of delay");

   a_ramp_step: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      state_reg == OOS_RAMP_DOWN && $past(state_reg) == OOS_RAMP_DOWN && vout_reg != $past(vout_reg)
         |-> vout_reg == $past(vout_reg) - 9'h001)
      else $error("ramp step not one unit");

   a_down_end: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      state_reg == OOS_RAMP_DOWN && vout_reg == 9'h000 && !turn_on_cmd_i && !turn_off_cmd_i
         |=> state_reg == OOS_OFF ##1 !stage_en_o)
      else $error("ramp-down did not end at zero");

   a_stage_zero: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      !stage_reg && state_reg == OOS_OFF |-> vout_reg == 9'h000)
      else $error("reference driven with switches open");

   a_droop_slope: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      $stable(vout_reg) && $stable(current_limit_setpoint_reg) && iout_i > $past(iout_i)
         |=> vout_ref_o <= $past(vout_ref_o))
      else $error("reference rose with current");

endmodule : oos_sequencer

// >>> output_turn_on_off_sequencer_tb_top.sv
// self-checking bench of the output sequencer with a shortened ms tick
// assumes the sequencer, its package and the host model are compiled first
`timescale 1ns/1ns

module output_turn_on_off_sequencer_tb_top;
   import oos_pkg::*;

   localparam int MS = 20;   // shortened ms tick, cycles

   logic       ref_clk_i;      // device clock
   logic       rst_i;          // synchronous reset
   logic [7:0] reg_addr;       // host address
   logic       reg_wr;         // host write
   logic       reg_rd;         // host read
   logic [7:0] reg_wdata;      // host data
   logic [7:0] reg_rdata_o;    // read data
   logic       on_cmd;         // turn-on pulse
   logic       off_cmd;        // turn-off pulse
   logic [8:0] target_steps;   // setpoint
   logic [7:0] iout;           // current monitor
   logic [8:0] vout_ref_o;     // reference out
   logic       stage_en_o;     // stage enable
   int         failures;       // mismatches
   int         checks;         // comparisons
   logic [7:0] rd;             // read result
   int         n;              // cycle count

   oos_sequencer #(.MS_TICK_CYCLES(MS), .STEP0_CYCLES(8), .STEP1_CYCLES(6)) oos_sequencer_inst
   (
      .ref_clk_i      (ref_clk_i),
      .rst_i          (rst_i),
      .reg_addr_i     (reg_addr),
      .reg_wr_i       (reg_wr),
      .reg_rd_i       (reg_rd),
      .reg_wdata_i    (reg_wdata),
      .reg_rdata_o    (reg_rdata_o),
      .turn_on_cmd_i  (on_cmd),
      .turn_off_cmd_i (off_cmd),
      .target_steps_i (target_steps),
      .iout_i         (iout),
      .vout_ref_o     (vout_ref_o),
      .stage_en_o     (stage_en_o)
   );

   oos_host_model oos_host_model_inst
   (
      .ref_clk_i   (ref_clk_i),
      .reg_addr_o  (reg_addr),
      .reg_wr_o    (reg_wr),
      .reg_rd_o    (reg_rd),
      .reg_wdata_o (reg_wdata),
      .reg_rdata_i (reg_rdata_o),
      .on_cmd_o    (on_cmd),
      .off_cmd_o   (off_cmd)
   );

   // ----------------------------------------------------------------
   // clock and reporting
   // ----------------------------------------------------------------
   initial
   begin
      ref_clk_i = 1'b0;
      forever #5 ref_clk_i = ~ref_clk_i;
   end

   task automatic give_verdict();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : give_verdict

   // value compare, case equality so unknowns never match
   task automatic check_val(input logic [8:0] got, input logic [8:0] exp, input string what);
      checks++;
      if (got !== exp)
      begin
         failures++;
         $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : check_val

   // cycle-count compare against a window
   task automatic check_range(input int got, input int lo, input int hi, input string what);
      checks++;
      if (got < lo || got > hi)
      begin
         failures++;
         $display("Error at %0t: %s took %0d cycles, window %0d..%0d", $time, what, got, lo, hi);
      end
   endtask : check_range

   // bounded wait for a stage enable level, counting edges
   task automatic wait_stage(input logic val, input int lim, output int cnt);
      cnt = 0;
      while (stage_en_o !== val && cnt < lim)
      begin
         @(posedge ref_clk_i);
         #1;
         cnt++;
      end
      if (stage_en_o !== val)
      begin
         failures++;
         $display("Error at %0t: stage enable wait ran out", $time);
         give_verdict();
      end
   endtask : wait_stage

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_registers();
      oos_host_model_inst.read_reg(8'h03, rd);
      check_val({1'b0, rd}, 9'h008, "track cfg reset");
      oos_host_model_inst.read_reg(8'h20, rd);
      check_val({1'b0, rd}, 9'h000, "unmapped read");
      oos_host_model_inst.write_reg(8'h05, 8'hFF);
      oos_host_model_inst.read_reg(8'h05, rd);
      check_val({1'b0, rd}, 9'h0FF, "on delay max");
      oos_host_model_inst.write_reg(8'h06, 8'hFF);
      oos_host_model_inst.read_reg(8'h06, rd);
      check_val({1'b0, rd}, 9'h03F, "off delay mask");
   endtask : t_registers

   // unslewed turn-on with no delay, then unslewed 2 ms turn-off
   task automatic t_unslewed();
      oos_host_model_inst.write_reg(8'h03, 8'h00);
      oos_host_model_inst.write_reg(8'h05, 8'h00);
      oos_host_model_inst.write_reg(8'h06, 8'h02);
      oos_host_model_inst.command(1'b1);
      wait_stage(1'b1, 10, n);
      check_range(n, 1, 3, "zero on delay");
      repeat (3) @(posedge ref_clk_i);
      check_val(vout_ref_o, 9'h028, "unslewed ramp");
      oos_host_model_inst.command(1'b0);
      wait_stage(1'b0, 80, n);
      check_range(n, 2 * MS - 1, 2 * MS + 3, "unslewed off delay");
      @(posedge ref_clk_i);
      #1;
      check_val(vout_ref_o, 9'h000, "unslewed off reference");
   endtask : t_unslewed

   // 3 ms turn-on restarted in mid-count by a second command
   task automatic t_restart();
      oos_host_model_inst.write_reg(8'h05, 8'h03);
      oos_host_model_inst.write_reg(8'h06, 8'h00);
      oos_host_model_inst.command(1'b1);
      repeat (30) @(posedge ref_clk_i);
      oos_host_model_inst.command(1'b1);
      wait_stage(1'b1, 100, n);
      check_range(n, 3 * MS - 1, 3 * MS + 3, "restarted on delay");
      oos_host_model_inst.command(1'b0);
      wait_stage(1'b0, 10, n);
      check_range(n, 0, 3, "zero off delay");
   endtask : t_restart

   // load regulation: droop of (32 * 1) >> 4 = 2 steps, then (64 * 3) >> 4 = 12 steps
   task automatic t_droop();
      oos_host_model_inst.write_reg(8'h05, 8'h00);
      oos_host_model_inst.write_reg(8'h08, 8'h01);
      iout <= 8'h20;
      oos_host_model_inst.command(1'b1);
      wait_stage(1'b1, 10, n);
      repeat (4) @(posedge ref_clk_i);
      check_val(vout_ref_o, 9'h026, "droop at load");
      iout <= 8'h00;
      repeat (3) @(posedge ref_clk_i);
      check_val(vout_ref_o, 9'h028, "droop at no load");
      oos_host_model_inst.write_reg(8'h08, 8'h03);
      iout <= 8'h40;
      repeat (3) @(posedge ref_clk_i);
      check_val(vout_ref_o, 9'h01C, "droop at gain 3");
      iout <= 8'h00;
      oos_host_model_inst.command(1'b0);
      wait_stage(1'b0, 10, n);
      oos_host_model_inst.write_reg(8'h08, 8'h00);
   endtask : t_droop

   // slewed ramps at code 0 (8 cycles a step) to 4 steps, 3 ms turn-off
   task automatic t_slewed();
      logic [8:0] prev;
      logic       jump;
      oos_host_model_inst.write_reg(8'h03, 8'h08);
      target_steps <= 9'h004;
      oos_host_model_inst.command(1'b1);
      wait_stage(1'b1, 10, n);
      prev = 9'h000;
      jump = 1'b0;
      for (n = 0; n < 100 && vout_ref_o !== 9'h004; n++)
      begin
         @(posedge ref_clk_i);
         #1;
         if (vout_ref_o > prev + 9'h001)
            jump = 1'b1;
         prev = vout_ref_o;
      end
      check_range(n, 24, 44, "slewed ramp up");
      check_val({8'h00, jump}, 9'h000, "single steps");
      oos_host_model_inst.write_reg(8'h06, 8'h03);
      oos_host_model_inst.command(1'b0);
      repeat (20) @(posedge ref_clk_i);
      check_val(vout_ref_o, 9'h004, "hold before ramp down");
      wait_stage(1'b0, 80, n);
      check_range(n + 20, 3 * MS - 2, 3 * MS + 4, "slewed off delay");
      check_val(vout_ref_o, 9'h000, "ramped to zero");
   endtask : t_slewed

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial
   begin
      failures     = 0;
      checks       = 0;
      rst_i        = 1'b1;
      target_steps = 9'h028;
      iout         = 8'h00;
      repeat (4) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      t_registers();
      t_unslewed();
      t_restart();
      t_droop();
      t_slewed();
      give_verdict();
   end

endmodule : output_turn_on_off_sequencer_tb_top
